// File: verilog/sfs_front_end.sv
// Serial flash SPI front end: link shifters, crossings and decode
`timescale 1ns/1ps
`default_nettype none

module sfs_front_end
  import sfs_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_wp_n,
  input wire logic i_dual_data_line_zero,
  output logic o_dual_data_line_zero,
  output logic o_dual_data_line_zero_oe,
  output logic o_dual_data_line_one,
  output logic o_dual_data_line_one_oe,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  input wire logic i_rx_ready,
  output logic o_rx_overrun,
  output logic o_addr_valid,
  output logic [7:0] o_cmd,
  output logic [ADDR_W-1:0] o_addr,
  output logic [11:0] o_page,
  output logic [7:0] o_sector,
  output logic [4:0] o_block32,
  output logic [3:0] o_block64,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready,
  output logic o_frame_active,
  output logic o_write_done,
  output logic o_write_rejected,
  output logic o_hw_protect
);

  // ----------------------------------------
  // State types
  // ----------------------------------------

  // Link rising edge state, cleared while deselected
  typedef struct packed {
    logic [2:0] bitc;
    logic [2:0] bytec;
    logic [7:0] sh;
    logic [7:0] cmd;
    logic tx_en;
    logic dual;
  } sfs_rise_t;

  // Link rising edge state that must outlive the frame
  typedef struct packed {
    logic rx_tgl;
    logic hdr_tgl;
    logic part;
    logic [7:0] rx_byte;
    logic [23:0] addr;
  } sfs_keep_t;

  // Link falling edge output state, cleared while deselected
  typedef struct packed {
    logic [2:0] cnt;
    logic [7:0] sh;
    logic d0;
    logic d1;
    logic oe0;
    logic oe1;
  } sfs_fall_t;

  // Link falling edge handshake state
  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic ack;
  } sfs_hand_t;

  // System clock state
  typedef struct packed {
    logic rx_seen;
    logic hdr_seen;
    logic cs_prev;
    logic first;
    logic active;
    logic [7:0] cmd;
    logic [ADDR_W-1:0] addr;
    logic addr_valid;
    logic req;
    logic pend;
    logic [7:0] tx_data;
    logic tx_ready;
    logic ovr;
    logic done;
    logic rej;
    logic hw_prot;
  } sfs_core_t;

  sfs_rise_t r_q, r_d;
  sfs_keep_t k_q, k_d;
  sfs_fall_t f_q, f_d;
  sfs_hand_t h_q, h_d;
  sfs_core_t c_q, c_d;

  logic sy_cs, sy_wp, sy_rx, sy_hdr, sy_part, sy_ack;
  logic fifo_ready;
  logic rx_evt, hdr_evt, frame_start, frame_end;

  // ----------------------------------------
  // Link side, rising edge
  // ----------------------------------------

  // Input shifter and frame decoder
  always_comb
  begin
    logic [7:0] b;
    logic [7:0] cmd_now;
    b = '0;
    cmd_now = '0;
    r_d = r_q;
    k_d = k_q;
    b = {r_q.sh[6:0], i_dual_data_line_zero};
    r_d.sh = b;
    r_d.bitc = r_q.bitc + 3'h1;
    k_d.part = (r_q.bitc != BIT_LAST);
    if (r_q.bitc == BIT_LAST)
    begin
      if (r_q.bytec != BYTE_MAX)
      begin
        r_d.bytec = r_q.bytec + 3'h1;
      end
      cmd_now = (r_q.bytec == BYTE_CMD) ? b : r_q.cmd;
      if (r_q.bytec == BYTE_CMD)
      begin
        r_d.cmd = b;
      end
      if ((r_q.bytec != BYTE_CMD) && (r_q.bytec <= ADDR_LAST))
      begin
        k_d.addr = {k_q.addr[15:0], b};
      end
      if (r_q.bytec == ADDR_LAST)
      begin
        k_d.hdr_tgl = ~k_q.hdr_tgl;
      end
      // Bytes seen while sending are not input
      if (!r_q.tx_en)
      begin
        k_d.rx_byte = b;
        k_d.rx_tgl = ~k_q.rx_tgl;
      end
      if (is_read_cmd(cmd_now) &&
          (r_q.bytec + 3'h1 == hdr_len(cmd_now)))
      begin
        r_d.tx_en = 1'b1;
        r_d.dual = (cmd_now == CMD_DUAL_READ);
      end
    end
  end

  always_ff @(posedge i_sclk or posedge i_cs_n)
  begin
    if (i_cs_n)
    begin
      r_q <= '0;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // Crossing toggles and held words
  always_ff @(posedge i_sclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      k_q <= '0;
    end
    else
    begin
      k_q <= k_d;
    end
  end

  // ----------------------------------------
  // Link side, falling edge
  // ----------------------------------------

  // Output shifter and byte fetch
  always_comb
  begin
    logic [7:0] nb;
    nb = f_q.sh;
    f_d = f_q;
    h_d = h_q;
    h_d.req_s1 = c_q.req;
    h_d.req_s2 = h_q.req_s1;
    if (r_q.tx_en)
    begin
      if (f_q.cnt == BIT_ZERO)
      begin
        nb = TX_FILL;
        if (h_q.req_s2 != h_q.ack)
        begin
          nb = c_q.tx_data;
          h_d.ack = ~h_q.ack;
        end
      end
      f_d.d1 = nb[7];
      if (r_q.dual)
      begin
        f_d.d0 = nb[6];
        f_d.oe0 = 1'b1;
        f_d.oe1 = 1'b1;
        f_d.sh = {nb[5:0], 2'b00};
        f_d.cnt = (f_q.cnt == DUAL_LAST) ? BIT_ZERO : f_q.cnt + 3'h1;
      end
      else
      begin
        f_d.oe1 = 1'b1;
        f_d.sh = {nb[6:0], 1'b0};
        f_d.cnt = f_q.cnt + 3'h1;
      end
    end
  end

  always_ff @(negedge i_sclk or posedge i_cs_n)
  begin
    if (i_cs_n)
    begin
      f_q <= '0;
    end
    else
    begin
      f_q <= f_d;
    end
  end

  // Handshake flops survive deselect
  always_ff @(negedge i_sclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      h_q <= '0;
    end
    else
    begin
      h_q <= h_d;
    end
  end

  assign o_dual_data_line_zero = f_q.d0;
  assign o_dual_data_line_zero_oe = f_q.oe0;
  assign o_dual_data_line_one = f_q.d1;
  assign o_dual_data_line_one_oe = f_q.oe1;

  // ----------------------------------------
  // Crossings into the system clock
  // ----------------------------------------

  // Pins, link toggles and the partial-byte flag, two stages each
  sfs_sync #(
    .W(6),
    .RST_VAL(6'h30)
  ) u_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async({i_cs_n, i_wp_n, k_q.rx_tgl, k_q.hdr_tgl, k_q.part, h_q.ack}),
    .o_sync({sy_cs, sy_wp, sy_rx, sy_hdr, sy_part, sy_ack})
  );

  // Received byte stream buffer
  sfs_fifo #(
    .W(FIFO_W),
    .D(FIFO_D)
  ) u_fifo (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_valid(rx_evt),
    .i_data(k_q.rx_byte),
    .o_ready(fifo_ready),
    .o_valid(o_rx_valid),
    .o_data(o_rx_data),
    .i_ready(i_rx_ready)
  );

  // ----------------------------------------
  // System clock control
  // ----------------------------------------

  assign rx_evt = sy_rx ^ c_q.rx_seen;
  assign hdr_evt = sy_hdr ^ c_q.hdr_seen;
  assign frame_start = c_q.cs_prev & ~sy_cs;
  assign frame_end = ~c_q.cs_prev & sy_cs;

  // Frame tracking, decode and read staging
  always_comb
  begin
    c_d = c_q;
    c_d.rx_seen = sy_rx;
    c_d.hdr_seen = sy_hdr;
    c_d.cs_prev = sy_cs;
    c_d.addr_valid = 1'b0;
    c_d.done = 1'b0;
    c_d.rej = 1'b0;
    c_d.hw_prot = ~sy_wp;
    if (frame_start)
    begin
      c_d.first = 1'b1;
      c_d.active = 1'b1;
      c_d.ovr = 1'b0;
    end
    if (rx_evt)
    begin
      if (c_q.first)
      begin
        c_d.cmd = k_q.rx_byte;
        c_d.first = 1'b0;
      end
      if (!fifo_ready)
      begin
        c_d.ovr = 1'b1;
      end
    end
    if (hdr_evt)
    begin
      c_d.addr = k_q.addr[ADDR_W-1:0];
      c_d.addr_valid = 1'b1;
    end
    if (c_q.pend && (sy_ack == c_q.req))
    begin
      c_d.pend = 1'b0;
    end
    if (i_tx_valid && c_q.tx_ready)
    begin
      c_d.tx_data = i_tx_data;
      c_d.req = ~c_q.req;
      c_d.pend = 1'b1;
    end
    if (frame_end)
    begin
      c_d.active = 1'b0;
      c_d.req = sy_ack;
      c_d.pend = 1'b0;
      if (is_write_cmd(c_q.cmd) && !c_q.first)
      begin
        c_d.rej = sy_part;
        c_d.done = ~sy_part;
      end
    end
    c_d.tx_ready = c_d.active && !c_d.pend && !frame_end;
  end

  // System clock state register
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      c_q <= '0;
      c_q.cs_prev <= 1'b1;
      c_q.first <= 1'b1;
    end
    else
    begin
      c_q <= c_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------

  assign o_rx_overrun = c_q.ovr;
  assign o_addr_valid = c_q.addr_valid;
  assign o_cmd = c_q.cmd;
  assign o_addr = c_q.addr;
  assign o_page = c_q.addr[ADDR_W-1:PAGE_LSB];
  // sector base is index times 4 KiB
  assign o_sector = c_q.addr[ADDR_W-1:SECTOR_LSB];
  assign o_block32 = c_q.addr[ADDR_W-1:BLK32_LSB];
  assign o_block64 = c_q.addr[ADDR_W-1:BLK64_LSB];
  assign o_tx_ready = c_q.tx_ready;
  assign o_frame_active = c_q.active;
  assign o_write_done = c_q.done;
  assign o_write_rejected = c_q.rej;
  assign o_hw_protect = c_q.hw_prot;

endmodule
`default_nettype wire

// File: verilog/sfs_pkg.sv
// Shared constants and decode helpers for the serial flash front end
package sfs_pkg;

  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_FAST_READ = 8'h0b;
  localparam logic [7:0] CMD_DUAL_READ = 8'h3b;
  localparam logic [7:0] CMD_PAGE_PROG = 8'h02;
  localparam logic [7:0] CMD_SECT_ERASE = 8'h20;
  localparam logic [7:0] CMD_BLK32_ERASE = 8'h52;
  localparam logic [7:0] CMD_BLK64_ERASE = 8'hd8;
  localparam logic [7:0] CMD_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] CMD_CHIP_ERASE_B = 8'hc7;
  localparam logic [7:0] CMD_WRITE_STAT = 8'h01;
  localparam logic [7:0] CMD_WRITE_EN = 8'h06;
  localparam logic [7:0] CMD_WRITE_DIS = 8'h04;
  localparam logic [7:0] CMD_POWER_DOWN = 8'hb9;

  // ----------------------------------------
  // Array organisation
  // ----------------------------------------
  localparam int ADDR_W = 20;
  localparam int PAGE_LSB = 8;
  localparam int SECTOR_LSB = 12;
  localparam int BLK32_LSB = 15;
  localparam int BLK64_LSB = 16;

  // ----------------------------------------
  // Frame counting
  // ----------------------------------------
  localparam logic [2:0] BIT_ZERO = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] DUAL_LAST = 3'h3;
  localparam logic [2:0] BYTE_CMD = 3'h0;
  localparam logic [2:0] ADDR_LAST = 3'h3;
  localparam logic [2:0] BYTE_MAX = 3'h7;
  localparam logic [2:0] HDR_PLAIN = 3'h4;
  localparam logic [2:0] HDR_DUMMY = 3'h5;
  localparam logic [7:0] TX_FILL = 8'hff;
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 16;

  // Commands that must end on a byte boundary
  function automatic logic is_write_cmd(input logic [7:0] c);
    return (c == CMD_PAGE_PROG) || (c == CMD_SECT_ERASE) ||
           (c == CMD_BLK32_ERASE) || (c == CMD_BLK64_ERASE) ||
           (c == CMD_CHIP_ERASE_A) || (c == CMD_CHIP_ERASE_B) ||
           (c == CMD_WRITE_STAT) || (c == CMD_WRITE_EN) ||
           (c == CMD_WRITE_DIS) || (c == CMD_POWER_DOWN);
  endfunction

  // Array reads handled by this front end
  function automatic logic is_read_cmd(input logic [7:0] c);
    return (c == CMD_READ) || (c == CMD_FAST_READ) || (c == CMD_DUAL_READ);
  endfunction

  // Header bytes before read data starts
  function automatic logic [2:0] hdr_len(input logic [7:0] c);
    return (c == CMD_READ) ? HDR_PLAIN : HDR_DUMMY;
  endfunction

endpackage

// File: verilog/sfs_sync.sv
// Two-stage level synchroniser into the system clock
`timescale 1ns/1ps
`default_nettype none

module sfs_sync
  import sfs_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sfs_sync_t;

  sfs_sync_t q, d;

  // First stage feeds only the second
  always_comb
  begin
    d.s1 = i_async;
    d.s2 = q.s1;
  end

  // Stage registers
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      q <= {RST_VAL, RST_VAL};
    end
    else
    begin
      q <= d;
    end
  end

  assign o_sync = q.s2;

endmodule
`default_nettype wire

// File: verilog/sfs_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module sfs_fifo
  import sfs_pkg::*;
#(
  parameter int W = FIFO_W,
  parameter int D = FIFO_D
)
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_valid,
  input wire logic [W-1:0] i_data,
  output logic o_ready,
  output logic o_valid,
  output logic [W-1:0] o_data,
  input wire logic i_ready
);

  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } sfs_fifo_t;

  sfs_fifo_t q, d;
  logic push, pop;

  assign o_ready = (q.cnt != (AW+1)'(D));
  assign o_valid = (q.cnt != '0);
  assign o_data = q.mem[q.rd];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  // Pointer and count update
  always_comb
  begin
    d = q;
    if (push)
    begin
      d.mem[q.wr] = i_data;
      d.wr = (q.wr == (AW)'(D - 1)) ? '0 : q.wr + 1'b1;
    end
    if (pop)
    begin
      d.rd = (q.rd == (AW)'(D - 1)) ? '0 : q.rd + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

endmodule
`default_nettype wire

// File: bench/sfs_front_end_assertions.sv
// Port-level checks for the serial flash front end
`timescale 1ns/1ps
`default_nettype none

module sfs_front_end_assertions
  import sfs_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_wp_n,
  input wire logic o_dual_data_line_zero_oe,
  input wire logic o_dual_data_line_one_oe,
  input wire logic o_rx_valid,
  input wire logic [7:0] o_rx_data,
  input wire logic i_rx_ready,
  input wire logic o_addr_valid,
  input wire logic [ADDR_W-1:0] o_addr,
  input wire logic [11:0] o_page,
  input wire logic [7:0] o_sector,
  input wire logic [4:0] o_block32,
  input wire logic [3:0] o_block64,
  input wire logic i_tx_valid,
  input wire logic o_tx_ready,
  input wire logic o_frame_active,
  input wire logic o_write_done,
  input wire logic o_write_rejected,
  input wire logic o_hw_protect
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  a_idle_float: assert property (
    i_cs_n |-> !o_dual_data_line_zero_oe && !o_dual_data_line_one_oe)
    else $error("enable while deselected");
  a_dual_pair: assert property (
    o_dual_data_line_zero_oe |-> o_dual_data_line_one_oe)
    else $error("line zero driven alone");
  a_rx_hold: assert property (
    o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_data))
    else $error("head byte moved");
  a_protect_on: assert property (
    (!i_wp_n) [*5] |-> o_hw_protect) else $error("protect missing");
  a_protect_off: assert property (
    (i_wp_n) [*5] |-> !o_hw_protect) else $error("protect stuck");
  a_page_field: assert property (
    o_page == o_addr[19:8]) else $error("page field wrong");
  a_sector_field: assert property (
    o_sector == o_addr[19:12]) else $error("sector field wrong");
  a_block_field: assert property (
    o_block32 == o_addr[19:15] && o_block64 == o_addr[19:16])
    else $error("block field wrong");
  a_end_pulse: assert property (
    o_write_done || o_write_rejected |->
      i_cs_n && !(o_write_done && o_write_rejected)
      ##1 !o_write_done && !o_write_rejected)
    else $error("frame end report wrong");
  a_tx_taken: assert property (
    o_tx_ready && i_tx_valid |=> !o_tx_ready)
    else $error("ready held after take");
  a_addr_pulse: assert property (
    o_addr_valid |-> o_frame_active ##1 !o_addr_valid)
    else $error("address pulse wrong");
endmodule

`default_nettype wire

// File: bench/sfs_host_model.sv
// Behavioural SPI host framing transfers to the front end
`timescale 1ns/1ps
`default_nettype none

module sfs_host_model
(
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_si,
  input wire logic i_so,
  input wire logic i_line_zero
);
  // ----------------------------------------
  // Framing
  // ----------------------------------------
  // select held high when idle
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
  end

  // Send nb bits MSB first, then clock nr read cycles
  task automatic xfer(input logic md3, input logic dual, input int nb,
    input logic [63:0] tx, input int nr, output logic [15:0] rx);
    rx = '0;
    o_sclk = md3;
    #0.5;
    o_cs_n = 1'b0;
    for (int k = 0; k < nb + nr; k++)
    begin
      #6;
      o_sclk = 1'b0;
      o_si = (k < nb) ? tx[63-k] : ~o_si;
      #6;
      o_sclk = 1'b1;
      if (k >= nb)
        rx = dual ? {rx[13:0], i_so, i_line_zero} : {rx[14:0], i_so};
    end
    #6;
    o_sclk = md3;
    o_cs_n = 1'b1;
    o_si = ~o_si;
    #60;
  endtask
endmodule

`default_nettype wire

// File: bench/sfs_front_end_tb_top.sv
// Self-checking bench for the serial flash front end
`timescale 1ns/1ps
`default_nettype none

module sfs_front_end_tb_top
  import sfs_pkg::*;
;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic i_wp_n = 1'b1;
  logic i_rx_ready = 1'b0;
  logic i_tx_valid = 1'b0;
  logic [7:0] i_tx_data = 8'h00;
  wire logic sclk, cs_n, h_si, si_w, so_w;
  logic o_dual_data_line_zero, o_dual_data_line_zero_oe;
  logic o_dual_data_line_one, o_dual_data_line_one_oe;
  logic o_rx_valid, o_rx_overrun, o_addr_valid, o_tx_ready, o_frame_active;
  logic o_write_done, o_write_rejected, o_hw_protect;
  logic [7:0] o_rx_data, o_cmd, o_sector;
  logic [ADDR_W-1:0] o_addr;
  logic [11:0] o_page;
  logic [4:0] o_block32;
  logic [3:0] o_block64;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int n_done = 0;
  int n_rej = 0;
  logic [31:0] seed = 32'h48;
  logic [15:0] rx;
  logic [7:0] exp_q[$];
  logic [7:0] wcmd [10] = '{CMD_PAGE_PROG, CMD_SECT_ERASE, CMD_BLK32_ERASE,
    CMD_BLK64_ERASE, CMD_CHIP_ERASE_A, CMD_CHIP_ERASE_B, CMD_WRITE_STAT,
    CMD_WRITE_EN, CMD_WRITE_DIS, CMD_POWER_DOWN};
  logic [7:0] rcmd [3] = '{CMD_READ, CMD_FAST_READ, CMD_DUAL_READ};

  // ----------------------------------------
  // Wiring and helpers
  // ----------------------------------------
  // Released lines show a changing pattern
  assign si_w = o_dual_data_line_zero_oe ? o_dual_data_line_zero : h_si;
  assign so_w = o_dual_data_line_one_oe ? o_dual_data_line_one : ~h_si;
  always #5 i_clock = ~i_clock;

  sfs_host_model host (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(h_si),
    .i_so(so_w), .i_line_zero(si_w));

  sfs_front_end DUT (.i_clock, .i_rst, .i_sclk(sclk), .i_cs_n(cs_n),
    .i_wp_n, .i_dual_data_line_zero(si_w), .o_dual_data_line_zero,
    .o_dual_data_line_zero_oe, .o_dual_data_line_one,
    .o_dual_data_line_one_oe, .o_rx_valid, .o_rx_data, .i_rx_ready,
    .o_rx_overrun, .o_addr_valid, .o_cmd, .o_addr, .o_page, .o_sector,
    .o_block32, .o_block64, .i_tx_valid, .i_tx_data, .o_tx_ready,
    .o_frame_active, .o_write_done, .o_write_rejected, .o_hw_protect);

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Queue whole sent bytes, then run one frame
  task automatic frm(input logic md3, input logic dual, input int nb,
    input int nr, input logic [63:0] t);
    for (int j = 0; j < nb / 8; j++)
      exp_q.push_back(t[63-8*j -: 8]);
    host.xfer(md3, dual, nb, t, nr, rx);
    @(posedge i_clock);
  endtask

  // Offer two read bytes, each held until taken
  task automatic stage(input logic [15:0] w);
    for (int j = 0; j < 2; j++)
    begin
      i_tx_valid <= 1'b1;
      i_tx_data <= w[15-8*j -: 8];
      do @(posedge i_clock); while (o_tx_ready !== 1'b1);
    end
    i_tx_valid <= 1'b0;
  endtask

  // Cycle ceiling, end reports and buffer drain compare
  always @(posedge i_clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      num_errors++;
      end_of_test();
    end
    if (o_write_done === 1'b1)
      n_done++;
    if (o_write_rejected === 1'b1)
      n_rej++;
    if (o_rx_valid === 1'b1 && i_rx_ready === 1'b1)
      check(o_rx_data, exp_q.pop_front());
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    logic [7:0] c;
    logic [23:0] a;
    logic [15:0] w;
    logic [63:0] t;
    repeat (4) @(posedge i_clock);
    check({o_tx_ready, o_frame_active, o_rx_valid}, 0);
    i_rst <= 1'b0;
    i_rx_ready <= 1'b1;
    repeat (3) @(posedge i_clock);
    i_wp_n <= 1'b0;
    repeat (6) @(posedge i_clock);
    check(o_hw_protect, 1'b1);
    i_wp_n <= 1'b1;
    repeat (6) @(posedge i_clock);
    check(o_hw_protect, 1'b0);
    $display("protect pin test over");
    // Write codes: whole frames, then ragged ends
    for (int i = 0; i < 20; i++)
    begin
      c = wcmd[i % 10];
      frm(i[0], 1'b0, (i < 10) ? 16 : 19, 0, {c, 8'(rnd()), 48'h0});
      check(o_cmd, c);
    end
    check(n_done, 10);
    check(n_rej, 10);
    $display("write code test over");
    // Read codes with staged bytes, top sector once
    for (int i = 0; i < 3; i++)
    begin
      c = rcmd[i];
      a = (i == 1) ? 24'hfff000 : 24'(rnd());
      w = 16'(rnd());
      fork
        stage(w);
        frm(i[0], c == CMD_DUAL_READ, (c == CMD_READ) ? 32 : 40,
          (c == CMD_DUAL_READ) ? 8 : 16, {c, a, 32'h0});
      join
      if (c == CMD_DUAL_READ)
      begin
        // Dual bytes last four clocks, shorter than the staging round trip
        check(rx, {w[15:8], TX_FILL});
      end
      else
        check(rx, w);
      check(o_addr, a[19:0]);
      check(o_sector, a[19:12]);
    end
    check({o_dual_data_line_zero_oe, o_dual_data_line_one_oe}, 0);
    $display("read test over");
    // Stall the drain until the buffer refuses bytes
    i_rx_ready <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      t = {CMD_PAGE_PROG, 24'h0, rnd()};
      if (i < 2)
        frm(1'b0, 1'b0, 64, 0, t);
      else
        host.xfer(1'b1, 1'b0, 16, t, 0, rx);
    end
    check(o_rx_overrun, 1'b1);
    @(posedge i_clock);
    i_rx_ready <= 1'b1;
    repeat (25) @(posedge i_clock);
    check(o_rx_valid, 1'b0);
    check(exp_q.size(), 0);
    $display("buffer test over");
    end_of_test();
  end
endmodule

bind sfs_front_end sfs_front_end_assertions chk (.i_clock, .i_rst, .i_cs_n,
  .i_wp_n, .o_dual_data_line_zero_oe, .o_dual_data_line_one_oe,
  .o_rx_valid, .o_rx_data, .i_rx_ready, .o_addr_valid, .o_addr, .o_page,
  .o_sector, .o_block32, .o_block64, .i_tx_valid, .o_tx_ready,
  .o_frame_active, .o_write_done, .o_write_rejected, .o_hw_protect);

`default_nettype wire
